// >>> mbpt_top.sv
// Match-based PWM timer with Wishbone register slave
`timescale 1ns/10ps
module mbpt_top (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire mbpt_pkg::mbpt_wb_req_t wb_req_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    input  wire logic [1:0]           cap_i,
    input  wire logic                 lead_run_i,
    output logic                      lead_run_o,
    output logic [6:1]                pwm_o,
    output logic [3:0]                ext_match_o,
    output logic                      irq_o
);

    localparam int NM = mbpt_pkg::NUM_MATCH;
    localparam int NC = mbpt_pkg::NUM_CAP;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Byte-lane merge of a write
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Edge of interest for a two-bit rise/fall selection
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic rise,
                                      input logic fall);
        return (mode[0] & rise) | (mode[1] & fall);
    endfunction : edge_hit

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] ir_r, mask_r, tcr_r, tc_r, pr_r, pc_r, mcr_r;
    logic [31:0] ccr_r, emr_r, ctcr_r, pcr_r, ler_r;
    logic [31:0] mr_sh_r  [NM];
    logic [31:0] mr_act_r [NM];
    logic [31:0] cr_r     [NC];
    logic [1:0]  cap_prev_r;
    logic        ack_r;
    logic [31:0] rd_nxt;

    // Bus decode
    logic        req, wr, wr_ir, wr_tcr, wr_tc;
    logic [NM-1:0] wr_mr;
    assign req    = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
    assign wr     = req & wb_req_i.we;
    assign wr_ir  = wr & (wb_req_i.adr == mbpt_pkg::OFF_IR);
    assign wr_tcr = wr & (wb_req_i.adr == mbpt_pkg::OFF_TCR);
    assign wr_tc  = wr & (wb_req_i.adr == mbpt_pkg::OFF_TC);
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            wr_mr[i] = wr & (wb_req_i.adr ==
                       8'(mbpt_pkg::OFF_MR0 + 8'(4 * i)));
        end
    end

    // ****************************************************************
    // Count source and prescaler
    // ****************************************************************
    logic       run, hold, src, tick, pwm_en, sel_rise, sel_fall;
    logic [1:0] cap_rise, cap_fall;
    logic [NM-1:0] match, mrst, mstop;
    assign cap_rise = cap_i & ~cap_prev_r;
    assign cap_fall = ~cap_i & cap_prev_r;
    assign sel_rise = cap_rise[ctcr_r[mbpt_pkg::CTCR_SEL]];
    assign sel_fall = cap_fall[ctcr_r[mbpt_pkg::CTCR_SEL]];
    assign pwm_en   = tcr_r[mbpt_pkg::TCR_PWM];
    assign hold     = tcr_r[mbpt_pkg::TCR_RST];
    // Follower waits on the lead's run level for lockstep start
    assign run = tcr_r[mbpt_pkg::TCR_EN] & ~hold &
                 (~tcr_r[mbpt_pkg::TCR_FOLLOW] | lead_run_i);
    // Timer counts every clock, counter counts chosen input edges
    assign src = (ctcr_r[1:0] == mbpt_pkg::SRC_TIMER) ? 1'b1 :
                 edge_hit(ctcr_r[1:0], sel_rise, sel_fall);
    assign tick = run & src & (pc_r == pr_r);

    // Match detection and per-match action decode
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            match[i] = tick & (tc_r == mr_act_r[i]);
            mrst[i]  = match[i] &
                       mcr_r[mbpt_pkg::MCR_W*i + mbpt_pkg::MCR_RST];
            mstop[i] = match[i] &
                       mcr_r[mbpt_pkg::MCR_W*i + mbpt_pkg::MCR_STOP];
        end
    end

    // Prescale counter, wraps at the limit to make one tick
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r <= mbpt_pkg::RST_ZERO;
        end else if (hold) begin
            pc_r <= mbpt_pkg::RST_ZERO;
        end else if (run & src) begin
            pc_r <= (pc_r == pr_r) ? mbpt_pkg::RST_ZERO : pc_r + 32'h1;
        end
    end

    // Main counter; match 0 closes the period in modulation mode
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tc_r <= mbpt_pkg::RST_ZERO;
        end else if (hold) begin
            tc_r <= mbpt_pkg::RST_ZERO;
        end else if (wr_tc) begin
            tc_r <= lane_merge(tc_r, wb_req_i.dat, wb_req_i.sel);
        end else if (tick) begin
            if ((|mrst) | (match[0] & pwm_en)) begin
                tc_r <= mbpt_pkg::RST_ZERO;
            end else begin
                tc_r <= tc_r + 32'h1;
            end
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Stop on match clears enable; hardware stop beats a software set
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tcr_r  <= mbpt_pkg::RST_ZERO;
            pr_r   <= mbpt_pkg::RST_ZERO;
            mcr_r  <= mbpt_pkg::RST_ZERO;
            ccr_r  <= mbpt_pkg::RST_ZERO;
            ctcr_r <= mbpt_pkg::RST_ZERO;
            pcr_r  <= mbpt_pkg::RST_ZERO;
            mask_r <= mbpt_pkg::RST_ZERO;
        end else begin
            if (wr_tcr) begin
                tcr_r <= lane_merge(tcr_r, wb_req_i.dat, wb_req_i.sel);
            end
            if (|mstop) begin
                tcr_r[mbpt_pkg::TCR_EN] <= 1'b0;
            end
            if (wr) begin
                case (wb_req_i.adr)
                    mbpt_pkg::OFF_PR: begin
                        pr_r <= lane_merge(pr_r, wb_req_i.dat, wb_req_i.sel);
                    end
                    mbpt_pkg::OFF_MCR: begin
                        mcr_r <= lane_merge(mcr_r, wb_req_i.dat,
                                            wb_req_i.sel);
                    end
                    mbpt_pkg::OFF_CCR: begin
                        ccr_r <= lane_merge(ccr_r, wb_req_i.dat,
                                            wb_req_i.sel);
                    end
                    mbpt_pkg::OFF_CTCR: begin
                        ctcr_r <= lane_merge(ctcr_r, wb_req_i.dat,
                                             wb_req_i.sel);
                    end
                    mbpt_pkg::OFF_PCR: begin
                        pcr_r <= lane_merge(pcr_r, wb_req_i.dat,
                                            wb_req_i.sel);
                    end
                    mbpt_pkg::OFF_MASK: begin
                        mask_r <= lane_merge(mask_r, wb_req_i.dat,
                                             wb_req_i.sel);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Match values: shadow, release and active copies
    // ****************************************************************
    // Outside modulation mode writes take effect at once; inside it a
    // released value waits for the period boundary so no runt appears
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ler_r <= mbpt_pkg::RST_ZERO;
            for (int i = 0; i < NM; i++) begin
                mr_sh_r[i]  <= mbpt_pkg::RST_ZERO;
                mr_act_r[i] <= mbpt_pkg::RST_ZERO;
            end
        end else begin
            for (int i = 0; i < NM; i++) begin
                if (wr_mr[i]) begin
                    mr_sh_r[i] <= lane_merge(mr_sh_r[i], wb_req_i.dat,
                                             wb_req_i.sel);
                end
                if (!pwm_en) begin
                    mr_act_r[i] <= mr_sh_r[i];
                end else if (match[0] & ler_r[i]) begin
                    mr_act_r[i] <= mr_sh_r[i];
                    ler_r[i]    <= 1'b0;
                end
            end
            // Release request; a new release beats the hardware clear
            if (wr & (wb_req_i.adr == mbpt_pkg::OFF_LER)) begin
                for (int i = 0; i < NM; i++) begin
                    if (wb_req_i.sel[0] & wb_req_i.dat[i]) begin
                        ler_r[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Modulated outputs
    // ****************************************************************
    // Single edge: set by match 0, cleared by own match. Double edge:
    // set by match n-1, cleared by match n. Clear wins a tie, so a
    // value equal to match 0 gives a constant low output.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_o <= 6'h00;
        end else begin
            for (int n = 1; n < NM; n++) begin
                if (!pwm_en | !pcr_r[mbpt_pkg::PCR_ENA0 + n]) begin
                    pwm_o[n] <= 1'b0;
                end else if (match[n]) begin
                    pwm_o[n] <= 1'b0;
                end else if (pcr_r[mbpt_pkg::PCR_SEL0 + n] && n > 1) begin
                    if (match[n-1]) begin
                        pwm_o[n] <= 1'b1;
                    end
                end else if (match[0]) begin
                    pwm_o[n] <= 1'b1;
                end
            end
        end
    end

    // External match outputs, two action bits each
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            emr_r <= mbpt_pkg::RST_ZERO;
        end else begin
            if (wr & (wb_req_i.adr == mbpt_pkg::OFF_EMR)) begin
                emr_r <= lane_merge(emr_r, wb_req_i.dat, wb_req_i.sel);
            end
            for (int e = 0; e < mbpt_pkg::NUM_EXT; e++) begin
                if (match[e]) begin
                    case (emr_r[mbpt_pkg::EMR_CTL0 + 2*e +: 2])
                        mbpt_pkg::EM_LOW:    emr_r[e] <= 1'b0;
                        mbpt_pkg::EM_HIGH:   emr_r[e] <= 1'b1;
                        mbpt_pkg::EM_TOGGLE: emr_r[e] <= ~emr_r[e];
                        default:             emr_r[e] <= emr_r[e];
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Capture
    // ****************************************************************
    logic [NC-1:0] cap_evt;
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            cap_evt[c] = edge_hit(
                ccr_r[mbpt_pkg::CCR_W*c + mbpt_pkg::CCR_RISE +: 2],
                cap_rise[c], cap_fall[c]);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_prev_r <= 2'h0;
            for (int c = 0; c < NC; c++) begin
                cr_r[c] <= mbpt_pkg::RST_ZERO;
            end
        end else begin
            cap_prev_r <= cap_i;
            for (int c = 0; c < NC; c++) begin
                if (cap_evt[c]) begin
                    cr_r[c] <= tc_r;
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt status and output
    // ****************************************************************
    // Event set wins over a write-one clear in the same cycle
    logic [31:0] ir_set;
    always_comb begin
        ir_set = mbpt_pkg::RST_ZERO;
        for (int i = 0; i < NM; i++) begin
            ir_set[i] = match[i] &
                        mcr_r[mbpt_pkg::MCR_W*i + mbpt_pkg::MCR_INT];
        end
        for (int c = 0; c < NC; c++) begin
            ir_set[mbpt_pkg::IR_CAP0 + c] = cap_evt[c] &
                ccr_r[mbpt_pkg::CCR_W*c + mbpt_pkg::CCR_INT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir_r  <= mbpt_pkg::RST_ZERO;
            irq_o <= 1'b0;
        end else begin
            ir_r  <= (ir_r & ~(wr_ir ? lane_merge(32'h0, wb_req_i.dat,
                      wb_req_i.sel) : 32'h0)) | ir_set;
            irq_o <= |(ir_r & mask_r);
        end
    end

    // ****************************************************************
    // Wishbone slave: one wait state, unmapped reads return zero
    // ****************************************************************
    always_comb begin
        rd_nxt = mbpt_pkg::RST_ZERO;
        case (wb_req_i.adr)
            mbpt_pkg::OFF_IR:   rd_nxt = ir_r;
            mbpt_pkg::OFF_TCR:  rd_nxt = tcr_r;
            mbpt_pkg::OFF_TC:   rd_nxt = tc_r;
            mbpt_pkg::OFF_PR:   rd_nxt = pr_r;
            mbpt_pkg::OFF_PC:   rd_nxt = pc_r;
            mbpt_pkg::OFF_MCR:  rd_nxt = mcr_r;
            mbpt_pkg::OFF_CCR:  rd_nxt = ccr_r;
            mbpt_pkg::OFF_EMR:  rd_nxt = emr_r;
            mbpt_pkg::OFF_CTCR: rd_nxt = ctcr_r;
            mbpt_pkg::OFF_PCR:  rd_nxt = pcr_r;
            mbpt_pkg::OFF_LER:  rd_nxt = ler_r;
            mbpt_pkg::OFF_MASK: rd_nxt = mask_r;
            default: begin
                for (int i = 0; i < NM; i++) begin
                    if (wb_req_i.adr == 8'(mbpt_pkg::OFF_MR0 + 8'(4*i))) begin
                        rd_nxt = mr_sh_r[i];
                    end
                end
                for (int c = 0; c < NC; c++) begin
                    if (wb_req_i.adr == 8'(mbpt_pkg::OFF_CR0 + 8'(4*c))) begin
                        rd_nxt = cr_r[c];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r      <= 1'b0;
            wb_dat_o   <= mbpt_pkg::RST_ZERO;
            lead_run_o <= 1'b0;
        end else begin
            ack_r      <= req;
            wb_dat_o   <= req ? rd_nxt : mbpt_pkg::RST_ZERO;
            lead_run_o <= run;
        end
    end
    assign wb_ack_o = ack_r;
    assign ext_match_o = emr_r[3:0];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Bus release of match 1 in this cycle, which keeps its flag set
    logic rel_wr1;
    assign rel_wr1 = wr & (wb_req_i.adr == mbpt_pkg::OFF_LER) &
                     wb_req_i.sel[0] & wb_req_i.dat[1];

    sequence s_period_end;
        pwm_en & match[0] & ~wr_tc;
    endsequence
    sequence s_release1;
        pwm_en & match[0] & ler_r[1];
    endsequence

    property p_prescale;
        tick |=> pc_r == mbpt_pkg::RST_ZERO;
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("tick without prescale wrap");

    property p_period_reset;
        s_period_end |=> tc_r == 32'h0;
    endproperty
    a_period_reset: assert property (p_period_reset)
        else $error("counter not reset at period end");

    property p_single_rise;
        pwm_en & pcr_r[mbpt_pkg::PCR_ENA0 + 1] & match[0] & ~match[1]
            |=> pwm_o[1];
    endproperty
    a_single_rise: assert property (p_single_rise)
        else $error("single edge output did not rise");

    property p_fall;
        pwm_en & match[2] |=> !pwm_o[2];
    endproperty
    a_fall: assert property (p_fall)
        else $error("output did not fall on its match");

    property p_release;
        s_release1 |=> (mr_act_r[1] == $past(mr_sh_r[1])) &
                       (ler_r[1] == $past(rel_wr1));
    endproperty
    a_release: assert property (p_release)
        else $error("released value not loaded at period start");

    property p_hold_active;
        pwm_en & !match[0] & $stable(pwm_en) |=> $stable(mr_act_r[1]);
    endproperty
    a_hold_active: assert property (p_hold_active)
        else $error("active match changed mid period");

    property p_stop;
        |mstop |=> !tcr_r[mbpt_pkg::TCR_EN] ##1 $stable(tc_r);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter kept running after stop");

    property p_capture;
        cap_evt[0] |=> cr_r[0] == $past(tc_r);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not hold counter value");

    property p_ack;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer not a single pulse");

    property p_irq;
        |(ir_r & mask_r) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

endmodule : mbpt_top

// >>> mbpt_pkg.sv
// Constants, register map and bus carrier of the match-based PWM timer
// Behaviour
// - 32-bit counter, 32-bit programmable prescaler
// - timer from clock or counter from capture edges
// - seven match registers, six outputs, mixed types
// - per match: continue, stop or reset, interrupt
// - in modulation mode match 0 resets counter, starts new period
// - single-edge output rises at period start
// - single-edge output uses one own match register
// - double-edge output uses rise and fall matches
// - rise before fall positive, otherwise negative pulse
// - period and width any whole tick count
// - software releases new values, applied glitch free
// - modulation off gives plain timer and capture
// - two instances lockstep, lead and follower
// - match outputs go low, high, toggle, hold
// - capture edge copies counter, optional interrupt
package mbpt_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_MATCH = 7;
    localparam int NUM_CAP   = 2;
    localparam int NUM_EXT   = 4;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_IR   = 8'h00; // Sticky event status, W1C
    localparam logic [7:0] OFF_TCR  = 8'h04; // Timer control
    localparam logic [7:0] OFF_TC   = 8'h08; // Counter value
    localparam logic [7:0] OFF_PR   = 8'h0C; // Prescale limit
    localparam logic [7:0] OFF_PC   = 8'h10; // Prescale counter
    localparam logic [7:0] OFF_MCR  = 8'h14; // Match actions
    localparam logic [7:0] OFF_MR0  = 8'h18; // Match 0..6 at +4 each
    localparam logic [7:0] OFF_CCR  = 8'h34; // Capture control
    localparam logic [7:0] OFF_CR0  = 8'h38; // Capture 0..1 at +4 each
    localparam logic [7:0] OFF_EMR  = 8'h40; // External match control
    localparam logic [7:0] OFF_CTCR = 8'h44; // Count source control
    localparam logic [7:0] OFF_PCR  = 8'h48; // Modulation control
    localparam logic [7:0] OFF_LER  = 8'h4C; // Match value release
    localparam logic [7:0] OFF_MASK = 8'h50; // Interrupt mask

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TCR_EN     = 0;  // Counter enable
    localparam int TCR_RST    = 1;  // Hold counter in reset
    localparam int TCR_PWM    = 3;  // Modulation mode enable
    localparam int TCR_FOLLOW = 4;  // Run only while lead runs
    localparam int IR_CAP0    = 7;  // Capture flags after match flags
    localparam int MCR_W      = 3;  // Per match: int, reset, stop
    localparam int MCR_INT    = 0;
    localparam int MCR_RST    = 1;
    localparam int MCR_STOP   = 2;
    localparam int CCR_W      = 3;  // Per capture: rise, fall, int
    localparam int CCR_RISE   = 0;
    localparam int CCR_FALL   = 1;
    localparam int CCR_INT    = 2;
    localparam int EMR_CTL0   = 4;  // Two control bits per output
    localparam int CTCR_SEL   = 2;  // Capture input used as source
    localparam int PCR_SEL0   = 0;  // Bit n: output n double edge, n 2..6 only
    localparam int PCR_ENA0   = 8;  // Bit 8+n: output n enabled

    // Count source modes and external match actions
    localparam logic [1:0] SRC_TIMER = 2'h0;
    localparam logic [1:0] SRC_RISE  = 2'h1;
    localparam logic [1:0] SRC_FALL  = 2'h2;
    localparam logic [1:0] SRC_BOTH  = 2'h3;
    localparam logic [1:0] EM_HOLD   = 2'h0;
    localparam logic [1:0] EM_LOW    = 2'h1;
    localparam logic [1:0] EM_HIGH   = 2'h2;
    localparam logic [1:0] EM_TOGGLE = 2'h3;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // ****************************************************************
    // Wishbone request carrier
    // ****************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } mbpt_wb_req_t;

endpackage : mbpt_pkg

// >>> mbpt_load_model.sv
// External load model: measures high time and period of one output
`timescale 1ns/10ps
module mbpt_load_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        pwm_i,
    output logic [31:0]      hi_o,
    output logic [31:0]      per_o
);
    logic [31:0] hi_r;
    logic [31:0] per_r;
    logic        prev_r;
    // Each rising edge closes one period, as a motor driver would see it
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {hi_r, per_r, prev_r, hi_o, per_o} <= '0;
        end else begin
            prev_r <= pwm_i;
            if (pwm_i && !prev_r) begin
                hi_o  <= hi_r;
                per_o <= per_r;
                hi_r  <= 32'h0000_0001;
                per_r <= 32'h0000_0001;
            end else begin
                hi_r  <= hi_r + {31'h0, pwm_i};
                per_r <= per_r + 32'h0000_0001;
            end
        end
    end
endmodule : mbpt_load_model

// >>> match_based_pwm_timer_tb_top.sv
// Self-checking testbench of the match-based PWM timer
`timescale 1ns/10ps
module match_based_pwm_timer_tb_top;
    logic sys_clk_i, rst_i, lead_run_o, wb_ack_o, irq_o, lead;
    logic [31:0] wb_dat_o, hi, per, rd, hi2, per2;
    logic [1:0] cap_i;
    logic [6:1] pwm_o;
    logic [3:0] ext_match_o;
    mbpt_pkg::mbpt_wb_req_t wb_req_i;
    int err_total, total_checks, cyc_n, mr1, act, lfsr;
    mbpt_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cap_i(cap_i),
        .lead_run_i(lead), .lead_run_o(lead_run_o), .pwm_o(pwm_o),
        .ext_match_o(ext_match_o), .irq_o(irq_o));
    mbpt_load_model load (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .pwm_i(pwm_o[1]), .hi_o(hi), .per_o(per));
    mbpt_load_model load2 (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .pwm_i(pwm_o[2]), .hi_o(hi2), .per_o(per2));
    // 25 ns clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            complete_run();
        end
    end
    function automatic int nxt(input int v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    // Classic cycle: held until ack is sampled high at an edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk_i);
        wb_req_i <= '{1'b1, 1'b1, we, 4'hF, a, d};
        do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req_i <= '0;
    endtask : wb
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_i = 1'b1;
        wb_req_i = '0;
        cap_i = 2'h0;
        lead = 1'b0;
        lfsr = 16;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wb(0, mbpt_pkg::OFF_TC, 0);
        chk("tc_reset", 0, rd);
        wb(0, 8'hFC, 0);
        chk("unmapped", 0, rd);
        // Single-edge output 1: period 8 ticks, high until match 1
        wb(1, mbpt_pkg::OFF_MR0, 7);
        wb(1, mbpt_pkg::OFF_MR0 + 8'h04, 3);
        act = 3;
        wb(1, mbpt_pkg::OFF_PCR, 32'h0000_0200);
        wb(1, mbpt_pkg::OFF_LER, 3);
        wb(1, mbpt_pkg::OFF_TCR, 9);
        tick(40);
        chk("period", 8, per);
        chk("high", act + 1, hi);
        // Unreleased widths must not reach the output
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            mr1 = lfsr % 6 + 1;
            wb(1, mbpt_pkg::OFF_MR0 + 8'h04, mr1);
            tick(30);
            chk("held", act + 1, hi);
            wb(1, mbpt_pkg::OFF_LER, 2);
            act = mr1;
            tick(30);
            chk("released", act + 1, hi);
            chk("rate", 8, per);
        end
        // Double edge output 2: rise at match 1, fall at match 2
        wb(1, mbpt_pkg::OFF_MR0 + 8'h08, 6);
        wb(1, mbpt_pkg::OFF_PCR, 32'h0000_0604);
        wb(1, mbpt_pkg::OFF_LER, 4);
        tick(30);
        chk("dbl_pos", 6 - act, hi2);
        chk("rate2", 8, per2);
        wb(1, mbpt_pkg::OFF_MR0 + 8'h08, 1);
        wb(1, mbpt_pkg::OFF_LER, 4);
        tick(30);
        chk("dbl_neg", 9 - act, hi2);
        // Match 0 interrupt, masked and cleared
        wb(1, mbpt_pkg::OFF_MCR, 1);
        wb(1, mbpt_pkg::OFF_MASK, 1);
        tick(20);
        chk("irq", 1, irq_o);
        wb(1, mbpt_pkg::OFF_MASK, 0);
        tick(3);
        chk("irq_mask", 0, irq_o);
        wb(1, mbpt_pkg::OFF_TCR, 0);
        wb(1, mbpt_pkg::OFF_IR, 32'h0000_007F);
        wb(0, mbpt_pkg::OFF_IR, 0);
        chk("ir_clear", 0, rd[0]);
        // Capture of a stopped counter gives its exact value
        lfsr = nxt(lfsr);
        wb(1, mbpt_pkg::OFF_TC, lfsr);
        wb(1, mbpt_pkg::OFF_CCR, 1);
        @(posedge sys_clk_i);
        cap_i <= 2'h1;
        tick(4);
        wb(0, mbpt_pkg::OFF_CR0, 0);
        chk("capture", lfsr, rd);
        // Plain timer: stop on match 0, every external action code
        wb(1, mbpt_pkg::OFF_MCR, 4);
        wb(1, mbpt_pkg::OFF_MR0, 5);
        for (int c = 0; c < 4; c++) begin
            wb(1, mbpt_pkg::OFF_TC, 0);
            wb(1, mbpt_pkg::OFF_EMR, (c << 4) | 1);
            wb(1, mbpt_pkg::OFF_TCR, 1);
            tick(12);
            chk("ext_match", 4'b0101 >> c & 1, ext_match_o[0]);
            chk("stopped", 0, lead_run_o);
            wb(0, mbpt_pkg::OFF_TCR, 0);
            chk("tcr_en", 0, rd[0]);
        end
        // Follower waits for the lead's run level
        wb(1, mbpt_pkg::OFF_TCR, 32'h0000_0011);
        tick(4);
        chk("follow_wait", 0, lead_run_o);
        lead <= 1'b1;
        tick(4);
        chk("follow_run", 1, lead_run_o);
        // Counter mode: rising edges of capture 0 clock the count
        wb(1, mbpt_pkg::OFF_TCR, 2);
        wb(1, mbpt_pkg::OFF_CTCR, 1);
        wb(1, mbpt_pkg::OFF_TCR, 1);
        repeat (3) begin
            cap_i <= 2'h0;
            tick(2);
            cap_i <= 2'h1;
            tick(2);
        end
        wb(0, mbpt_pkg::OFF_TC, 0);
        chk("count_src", 3, rd);
        complete_run();
    end
endmodule : match_based_pwm_timer_tb_top
